// >>> shared/cssq_pkg.sv
/*
 * Constants for the card session sequencer: register map, field
 * positions, reset values and sequencer step lengths.
 * Assumes a 10 MHz system clock and a 32-bit AHB-Lite register bus.
 */
package cssq_pkg;
    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET = 8'h00;    // Control
    localparam logic [7:0] STATUS_OFFSET = 8'h04;  // Live state
    localparam logic [7:0] EVENT_OFFSET = 8'h08;   // Sticky events, clear on read
    localparam logic [7:0] MASK_OFFSET = 8'h0C;    // Event mask

    // ----------------------------------------------------------------
    // Control fields
    // ----------------------------------------------------------------
    localparam int CTRL_START_BIT = 0;       // Activation request
    localparam int CTRL_RSTCTL_BIT = 1;      // Card reset control
    localparam int CTRL_DATA_BIT = 2;        // Data line level to card
    localparam int CTRL_DIV_LSB = 8;         // Sequencer divider field
    localparam int CTRL_DIV_W = 8;           // Divider field width
    localparam logic [7:0] DIV_RESET = 8'h07;  // Divider reload after reset

    // ----------------------------------------------------------------
    // Event bits (same layout in event and mask registers)
    // ----------------------------------------------------------------
    localparam int EV_ACTIVE_BIT = 0;    // Session became active
    localparam int EV_EMERG_BIT = 1;     // Emergency deactivation
    localparam int EV_DEACT_BIT = 2;     // Deactivation completed
    localparam int EV_CARD_PRESENT_INPUT_BIT = 3;      // Presence changed
    localparam int EV_W = 4;             // Number of event bits

    // ----------------------------------------------------------------
    // Sequencer step length in sequencer ticks
    // ----------------------------------------------------------------
    localparam logic [3:0] STEP_TICKS = 4'h4;

    // Sequencer states
    typedef enum logic [3:0] {
        SQ_IDLE = 4'b0000,
        SQ_BOOST = 4'b0001,
        SQ_VCC = 4'b0010,
        SQ_ACTIVE = 4'b0011,
        SQ_RSTLOW = 4'b0100,
        SQ_CLKSTOP = 4'b0101,
        SQ_DATAREL = 4'b0110,
        SQ_PWROFF = 4'b0111
    } cssq_state_e;
endpackage : cssq_pkg

// >>> verilog/cssq_sync.sv
/*
 * Two-flop synchroniser for a bundle of asynchronous pin inputs.
 * Assumes the inputs are quasi-static levels; one clock domain.
 */
`timescale 1ns/1ps
module cssq_sync #(
    parameter int WIDTH = 2  // Number of bits
) (
    input wire logic sys_clk,            // System clock
    input wire logic rst,                // Synchronous reset
    input wire logic [WIDTH-1:0] async,  // Asynchronous inputs
    output logic [WIDTH-1:0] synced      // Synchronised outputs
);
    logic [WIDTH-1:0] stage1;  // First stage, read only by second

    // Two flip-flop chain
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            stage1 <= '0;
            synced <= '0;
        end
        else
        begin
            stage1 <= async;
            synced <= stage1;
        end
    end
endmodule : cssq_sync

// >>> verilog/cssq_card_sequencer.sv
/*
 * Card session sequencer: activation and deactivation of the card
 * contacts, emergency shutdown, supply alarm routing, AHB-Lite slave.
 * Assumes a single 10 MHz clock; pins arrive asynchronously and are
 * synchronised here; the analog booster and card supply follow the
 * enable outputs.
 */
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps

// Operation
// RULE1: Activate only with card present, alarm idle
// RULE2: Reset control gates card clock and reset
// RULE3: Card off status shows card presence
// RULE4: Auto deactivate on removal, supply drop, fault
// RULE5: Emergency deactivation drives card off low
// RULE6: Booster enabled before card supply
// RULE7: Clamp off at supply rise, on after booster
// RULE8: Alarm resets controller alongside external reset
// RULE9: Alarm holds contacts idle, forces deactivation
// RULE10: Alarm output open-drain, polarity build option
// RULE11: Contacts idle during own power up/down
// RULE12: Sequencer clocked by divided oscillator
// RULE13: Sequencer runs in power-down and sleep
// RULE14: Deactivate: reset, clock, data, then power; code drops reset and clock together on entering SQ_RSTLOW
// RULE15: Controller checks presence, then releases reset
module cssq_card_sequencer #(
    parameter bit CARD_PRESENT_INPUT_ACTIVE_HIGH = 1'b1,  // Card present input polarity
    parameter bit ALARM_ACTIVE_HIGH = 1'b0  // Alarm output polarity
) (
    input wire logic sys_clk,             // 10 MHz clock
    input wire logic rst,                 // Synchronous reset, active high
    input wire logic [31:0] haddr,        // AHB address
    input wire logic [1:0] htrans,        // AHB transfer type
    input wire logic hwrite,              // AHB write
    input wire logic [2:0] hsize,         // AHB size
    input wire logic [31:0] hwdata,       // AHB write data
    input wire logic hsel,                // AHB select
    input wire logic hready,              // AHB ready in
    output logic [31:0] hrdata,           // AHB read data
    output logic hreadyout,               // AHB ready out
    output logic hresp,                   // AHB response
    input wire logic cardPresentInput,    // Card presence pin
    input wire logic supplyAlarm,         // Supply supervisor alarm pin
    input wire logic hwFault,             // Overload or fault pin
    input wire logic powerGood,           // Own supply settled pin
    input wire logic extResetIn,          // External reset pin, high
    input wire logic cardDataIn,          // Card data line input
    output logic cardDataOut,             // Card data line output
    output logic cardDataOe,              // Card data line drive enable
    output logic cardClk,                 // Card clock gate
    output logic cardRst,                 // Card reset output
    output logic cardVccEn,               // Card supply enable
    output logic boostEn,                 // Booster enable
    output logic lowImpedanceSupply,      // Contact clamp enable
    output logic cardOffStatusPort,       // Card off status to controller
    output logic ctrlReset,               // Controller reset
    output logic alarmOut,                // Alarm open-drain output level
    output logic alarmOe,                 // Alarm drive enable
    output logic irq                      // Interrupt, level high
);
    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    logic [5:0] pinSync;  // Synchronised pins
    cssq_sync #(.WIDTH(6)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .async({cardDataIn, extResetIn, powerGood, hwFault, supplyAlarm,
                cardPresentInput}),
        .synced(pinSync)
    );
    logic cardPresent;  // Presence, polarity resolved
    logic alarmSync;    // Alarm level
    logic faultSync;    // Fault level
    logic pwrGoodSync;  // Own supply good
    logic extRstSync;   // External reset level
    logic dataInSync;   // Card data line level
    assign cardPresent = (pinSync[0] == CARD_PRESENT_INPUT_ACTIVE_HIGH);
    assign alarmSync = pinSync[1];
    assign faultSync = pinSync[2];
    assign pwrGoodSync = pinSync[3];
    assign extRstSync = pinSync[4];
    assign dataInSync = pinSync[5];

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic activationRequest;      // Controller start request
    logic cardResetControl;       // Controller reset control line
    logic dataLevel;              // Data level to drive
    logic [7:0] divReload;        // Sequencer divider reload
    logic [cssq_pkg::EV_W-1:0] eventFlags;  // Sticky events
    logic [cssq_pkg::EV_W-1:0] eventMask;   // Event mask
    logic next_activationRequest;
    logic next_cardResetControl;
    logic next_dataLevel;
    logic [7:0] next_divReload;
    logic [cssq_pkg::EV_W-1:0] next_eventFlags;
    logic [cssq_pkg::EV_W-1:0] next_eventMask;
    logic [cssq_pkg::EV_W-1:0] eventSet;    // Events this cycle

    // Bus pipeline
    logic wrPend;                 // Write data phase pending
    logic rdPend;                 // Read data phase pending
    logic [7:0] phAddr;           // Latched address
    logic [31:0] next_hrdata;
    logic next_wrPend;
    logic next_rdPend;
    logic [7:0] next_phAddr;
    logic addrValid;              // Valid address phase
    assign addrValid = hsel && hready && htrans[1];

    // ----------------------------------------------------------------
    // Sequencer state
    // ----------------------------------------------------------------
    cssq_pkg::cssq_state_e state;
    cssq_pkg::cssq_state_e next_state;
    logic [7:0] divCnt;           // Divider count
    logic [7:0] next_divCnt;
    logic tick;                   // Sequencer enable pulse
    logic [3:0] stepCnt;          // Ticks within a step
    logic [3:0] next_stepCnt;
    logic emergency;              // Emergency latch for this shutdown
    logic next_emergency;
    logic presPrev;               // Presence last cycle
    logic stepDone;               // Step time elapsed

    // Read mux function
    function automatic logic [31:0] read_reg(input logic [7:0] addr,
                                             input logic [31:0] ctrlW,
                                             input logic [31:0] statW,
                                             input logic [31:0] evW,
                                             input logic [31:0] mskW);
        logic [31:0] val;
        val = 32'h0000_0000;
        if (addr == cssq_pkg::CTRL_OFFSET)
            val = ctrlW;
        else if (addr == cssq_pkg::STATUS_OFFSET)
            val = statW;
        else if (addr == cssq_pkg::EVENT_OFFSET)
            val = evW;
        else if (addr == cssq_pkg::MASK_OFFSET)
            val = mskW;
        return val;
    endfunction : read_reg

    logic [31:0] ctrlWord;   // Control readback
    logic [31:0] statWord;   // Status readback
    always_comb
    begin
        ctrlWord = 32'h0000_0000;
        ctrlWord[cssq_pkg::CTRL_START_BIT] = activationRequest;
        ctrlWord[cssq_pkg::CTRL_RSTCTL_BIT] = cardResetControl;
        ctrlWord[cssq_pkg::CTRL_DATA_BIT] = dataLevel;
        ctrlWord[cssq_pkg::CTRL_DIV_LSB +: cssq_pkg::CTRL_DIV_W] = divReload;
        statWord = {20'h0_0000, state, dataInSync, faultSync, alarmSync,
                    cardPresent, boostEn, cardVccEn, cardOffStatusPort, irq};
    end

    // Bus and register next values
    always_comb
    begin
        next_wrPend = addrValid && hwrite;
        next_rdPend = addrValid && !hwrite;
        next_phAddr = addrValid ? haddr[7:0] : phAddr;
        next_hrdata = hrdata;
        next_activationRequest = activationRequest;
        next_cardResetControl = cardResetControl;
        next_dataLevel = dataLevel;
        next_divReload = divReload;
        next_eventMask = eventMask;
        next_eventFlags = eventFlags;
        // Read data registered at address phase
        if (addrValid && !hwrite)
        begin
            next_hrdata = read_reg(haddr[7:0], ctrlWord, statWord,
                                   {28'h000_0000, eventFlags},
                                   {28'h000_0000, eventMask});
            // Clear on read
            if (haddr[7:0] == cssq_pkg::EVENT_OFFSET)
                next_eventFlags = '0;
        end
        // Write data phase
        if (wrPend)
        begin
            if (phAddr == cssq_pkg::CTRL_OFFSET)
            begin
                next_activationRequest = hwdata[cssq_pkg::CTRL_START_BIT];
                next_cardResetControl = hwdata[cssq_pkg::CTRL_RSTCTL_BIT];
                next_dataLevel = hwdata[cssq_pkg::CTRL_DATA_BIT];
                next_divReload = hwdata[cssq_pkg::CTRL_DIV_LSB +: cssq_pkg::CTRL_DIV_W];
            end
            else if (phAddr == cssq_pkg::MASK_OFFSET)
                next_eventMask = hwdata[cssq_pkg::EV_W-1:0];
        end
        // Set wins over clear
        next_eventFlags = next_eventFlags | eventSet;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            wrPend <= 1'b0;
            rdPend <= 1'b0;
            phAddr <= 8'h00;
            hrdata <= 32'h0000_0000;
            activationRequest <= 1'b0;
            cardResetControl <= 1'b0;
            dataLevel <= 1'b1;
            divReload <= cssq_pkg::DIV_RESET;
            eventMask <= '0;
            eventFlags <= '0;
        end
        else
        begin
            wrPend <= next_wrPend;
            rdPend <= next_rdPend;
            phAddr <= next_phAddr;
            hrdata <= next_hrdata;
            activationRequest <= next_activationRequest;
            cardResetControl <= next_cardResetControl;
            dataLevel <= next_dataLevel;
            divReload <= next_divReload;
            eventMask <= next_eventMask;
            eventFlags <= next_eventFlags;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    // RULE12: divided clock enable
    assign tick = (divCnt == 8'h00);
    assign stepDone = tick && (stepCnt == cssq_pkg::STEP_TICKS - 4'h1);
    logic killReq;  // Any emergency cause
    // RULE4: emergency causes
    assign killReq = !cardPresent || alarmSync || faultSync || !pwrGoodSync;

    // Next-state logic; runs in all power modes as it needs only sys_clk
    always_comb
    begin
        next_state = state;
        next_divCnt = tick ? divReload : divCnt - 8'h01;
        next_stepCnt = tick ? stepCnt + 4'h1 : stepCnt;
        next_emergency = emergency;
        eventSet = '0;
        if (cardPresent != presPrev)
            eventSet[cssq_pkg::EV_CARD_PRESENT_INPUT_BIT] = 1'b1;
        // RULE13: always-running sequencer
        case (state)
            cssq_pkg::SQ_IDLE:
            begin
                next_stepCnt = 4'h0;
                next_emergency = 1'b0;
                // RULE1: start qualification
                if (activationRequest && !killReq)
                    next_state = cssq_pkg::SQ_BOOST;
            end
            cssq_pkg::SQ_BOOST:
            begin
                // RULE6: booster before supply
                if (killReq || !activationRequest)
                begin
                    next_state = cssq_pkg::SQ_PWROFF;
                    next_emergency = killReq;
                end
                else if (stepDone)
                    next_state = cssq_pkg::SQ_VCC;
            end
            cssq_pkg::SQ_VCC, cssq_pkg::SQ_ACTIVE:
            begin
                // RULE9: alarm forces deactivation
                if (killReq || !activationRequest)
                begin
                    next_state = cssq_pkg::SQ_RSTLOW;
                    next_emergency = killReq;
                end
                else if (state == cssq_pkg::SQ_VCC && stepDone)
                begin
                    next_state = cssq_pkg::SQ_ACTIVE;
                    eventSet[cssq_pkg::EV_ACTIVE_BIT] = 1'b1;
                end
            end
            // RULE14: ordered shutdown steps
            cssq_pkg::SQ_RSTLOW, cssq_pkg::SQ_CLKSTOP, cssq_pkg::SQ_DATAREL:
            begin
                // Codes run in shutdown order
                if (stepDone)
                    next_state = cssq_pkg::cssq_state_e'(state + 4'h1);
            end
            cssq_pkg::SQ_PWROFF:
            begin
                if (stepDone)
                begin
                    next_state = cssq_pkg::SQ_IDLE;
                    eventSet[cssq_pkg::EV_DEACT_BIT] = 1'b1;
                    eventSet[cssq_pkg::EV_EMERG_BIT] = emergency;
                end
            end
            default:
                next_state = cssq_pkg::SQ_IDLE;
        endcase
        // Each new step starts its own tick count
        if (next_state != state)
            next_stepCnt = 4'h0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state <= cssq_pkg::SQ_IDLE;
            divCnt <= 8'h00;
            stepCnt <= 4'h0;
            emergency <= 1'b0;
            presPrev <= 1'b0;
        end
        else
        begin
            state <= next_state;
            divCnt <= next_divCnt;
            stepCnt <= next_stepCnt;
            emergency <= next_emergency;
            presPrev <= cardPresent;
        end
    end

    // ----------------------------------------------------------------
    // Contact outputs, all registered
    // ----------------------------------------------------------------
    logic next_boostEn, next_cardVccEn, next_cardClk, next_cardRst;
    logic next_cardDataOe, next_lis, next_offStatus, next_ctrlReset;
    logic next_alarmOe, next_irq;
    logic powered;   // Card supply on in next state
    always_comb
    begin
        // Supply on from the supply step up to the power-off step
        powered = (next_state >= cssq_pkg::SQ_VCC) && (next_state != cssq_pkg::SQ_PWROFF);
        // RULE6: booster up from first step
        next_boostEn = (next_state != cssq_pkg::SQ_IDLE);
        next_cardVccEn = powered;
        // RULE7: clamp off while supply rises
        next_lis = !(powered || (next_state == cssq_pkg::SQ_PWROFF && boostEn
                     && !stepDone));
        // RULE2: reset control gates clock and reset
        next_cardClk = (next_state == cssq_pkg::SQ_ACTIVE) && cardResetControl;
        next_cardRst = (next_state == cssq_pkg::SQ_ACTIVE) && cardResetControl;
        // RULE14: data line released last before power
        next_cardDataOe = powered && (next_state != cssq_pkg::SQ_DATAREL);
        // RULE3: presence status, RULE5: low on emergency
        next_offStatus = cardPresent && !next_emergency;
        // RULE8: alarm in parallel with external reset
        next_ctrlReset = alarmSync || extRstSync;
        // RULE10: open-drain, polarity by option
        next_alarmOe = (alarmSync == ALARM_ACTIVE_HIGH) ? 1'b0 : 1'b1;
        next_irq = |(next_eventFlags & next_eventMask);
        // RULE11: idle contacts without own supply
        if (!pwrGoodSync)
        begin
            next_cardVccEn = 1'b0;
            next_cardClk = 1'b0;
            next_cardRst = 1'b0;
            next_cardDataOe = 1'b0;
            next_lis = 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            boostEn <= 1'b0;
            cardVccEn <= 1'b0;
            cardClk <= 1'b0;
            cardRst <= 1'b0;
            cardDataOe <= 1'b0;
            cardDataOut <= 1'b0;
            lowImpedanceSupply <= 1'b1;
            cardOffStatusPort <= 1'b0;
            ctrlReset <= 1'b1;
            alarmOe <= 1'b0;
            alarmOut <= 1'b0;
            irq <= 1'b0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            boostEn <= next_boostEn;
            cardVccEn <= next_cardVccEn;
            cardClk <= next_cardClk;
            cardRst <= next_cardRst;
            cardDataOe <= next_cardDataOe;
            cardDataOut <= dataLevel;
            lowImpedanceSupply <= next_lis;
            cardOffStatusPort <= next_offStatus;
            ctrlReset <= next_ctrlReset;
            alarmOe <= next_alarmOe;
            alarmOut <= 1'b0;
            irq <= next_irq;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
endmodule : cssq_card_sequencer

// >>> verif/cssq_card_model.sv
/* Behavioural smart card on the contacts.
   Assumes an open-drain data line with a pull-up. */
`timescale 1ns/1ps
module cssq_card_model (
    input wire logic sys_clk, // Clock
    input wire logic cardVccEn, // Card supply
    input wire logic cardRst, // Reset released
    input wire logic cardDataOut, // Reader level
    input wire logic cardDataOe, // Reader drives
    output logic ioLine // Wire level
);
    logic cardLow = 1'b0; // Card pulls low
    // Card answers only when powered and out of reset
    always @(posedge sys_clk)
        cardLow <= cardVccEn && cardRst && !cardLow;
    // Pull-up wins when nobody pulls low
    assign ioLine = !((cardDataOe && !cardDataOut) || cardLow);
endmodule : cssq_card_model

// >>> verif/cssq_card_sequencer_chk.sv
/* Port checker for the card session sequencer.
   Assumes a bind onto cssq_card_sequencer, one clock domain. */
`timescale 1ns/1ps
module cssq_chk #(
    parameter bit ALARM_ACTIVE_HIGH = 1'b0 // Alarm polarity
) (
    input wire logic sys_clk, // Clock
    input wire logic rst, // Reset
    input wire logic cardPresentInput, // Presence
    input wire logic supplyAlarm, // Alarm pin
    input wire logic powerGood, // Own supply
    input wire logic cardClk, // Card clock
    input wire logic cardRst, // Card reset
    input wire logic cardVccEn, // Card supply
    input wire logic boostEn, // Booster
    input wire logic lowImpedanceSupply, // Clamp
    input wire logic cardDataOe, // Data drive
    input wire logic cardOffStatusPort, // Off status
    input wire logic ctrlReset, // Controller reset
    input wire logic alarmOut, // Alarm level
    input wire logic alarmOe // Alarm enable
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_boost; $rose(boostEn) |-> cardOffStatusPort; endproperty
    a_boost: assert property (p_boost) else $error("boost without card");
    property p_vcc; $rose(cardVccEn) |-> boostEn; endproperty
    a_vcc: assert property (p_vcc) else $error("supply before booster");
    property p_lisOff; $rose(cardVccEn) |-> ##[0:1] !lowImpedanceSupply; endproperty
    a_lisOff: assert property (p_lisOff) else $error("clamp kept");
    property p_lisOn; $fell(boostEn) |-> lowImpedanceSupply; endproperty
    a_lisOn: assert property (p_lisOn) else $error("clamp late");
    property p_clk; cardClk |-> cardVccEn && boostEn; endproperty
    a_clk: assert property (p_clk) else $error("clock unpowered");
    property p_dat; $fell(cardDataOe) |-> !cardClk && !cardRst; endproperty
    a_dat: assert property (p_dat) else $error("data released early");
    property p_off; $fell(cardVccEn) |-> !cardDataOe && !cardClk; endproperty
    a_off: assert property (p_off) else $error("power off early");
    property p_alarm;
        supplyAlarm [*4] |-> ctrlReset && alarmOe == !ALARM_ACTIVE_HIGH && !alarmOut;
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm not routed");
    property p_pg; !powerGood [*4] |-> ##[0:300] !cardVccEn; endproperty
    a_pg: assert property (p_pg) else $error("contacts live");
    property p_card_present_input; !cardPresentInput [*4] |-> !cardOffStatusPort; endproperty
    a_card_present_input: assert property (p_card_present_input) else $error("status wrong");
endmodule : cssq_chk
bind cssq_card_sequencer cssq_chk #(.ALARM_ACTIVE_HIGH(ALARM_ACTIVE_HIGH)) chk_u (.*);

// >>> verif/tb.sv
/* Self-checking bench for the card session sequencer.
   Assumes design, checker and card model are compiled first. */
`timescale 1ns/1ps
module tb;
    logic sys_clk = 1'b0, rst = 1'b1, hwrite = 1'b0, hsel = 1'b0, dBit;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
    logic hreadyout, hresp, card_present_input = 1'b1, alarm = 1'b0, fault = 1'b0, pg = 1'b1;
    logic extRst = 1'b0, ioLine, dOut, dOe, cClk, cRst, vcc, boost, low_impedance_supply;
    logic offSt, ctlRst, alOut, alOe, irq;
    logic [3:0] mask;
    int miscompares = 0, nCompared = 0, cyc = 0, i;
    // Clock and cycle ceiling
    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            results();
        end
    end
    cssq_card_sequencer dut_u (.sys_clk, .rst, .haddr, .htrans,
        .hwrite, .hsize(3'b010), .hwdata, .hsel, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .cardPresentInput(card_present_input),
        .supplyAlarm(alarm), .hwFault(fault), .powerGood(pg), .extResetIn(extRst),
        .cardDataIn(ioLine), .cardDataOut(dOut), .cardDataOe(dOe), .cardClk(cClk),
        .cardRst(cRst), .cardVccEn(vcc), .boostEn(boost), .lowImpedanceSupply(low_impedance_supply),
        .cardOffStatusPort(offSt), .ctrlReset(ctlRst), .alarmOut(alOut), .alarmOe(alOe),
        .irq);
    cssq_card_model card_u (.sys_clk, .cardVccEn(vcc), .cardRst(cRst),
        .cardDataOut(dOut), .cardDataOe(dOe), .ioLine);
    function automatic logic expIrq(input logic [3:0] ev, input logic [3:0] m);
        return |(ev & m);
    endfunction : expIrq
    task automatic check(input logic [31:0] exp, input logic [31:0] got);
        nCompared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : check
    // One single AHB-Lite transfer
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd = '0);
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        hsel <= 1'b1;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic ctl(input logic [31:0] v);
        bus(1'b1, cssq_pkg::CTRL_OFFSET, v);
    endtask : ctl
    task automatic waitFor(ref logic s, input logic v);
        for (int k = 0; k < 400 && s !== v; k++) @(posedge sys_clk);
        #1;
    endtask : waitFor
    task automatic results();
        if (miscompares == 0 && nCompared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    initial
    begin
        void'($urandom(8762));
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        bus(1'b0, cssq_pkg::CTRL_OFFSET);
        check(32'h0000_0704, rd);
        bus(1'b0, 8'h10);
        check(32'h0000_0000, rd);
        // Refused starts: absent card, alarm, fault
        for (i = 0; i < 3; i++)
        begin
            {card_present_input, alarm, fault} <= {i != 0, i == 1, i == 2};
            repeat (5) @(posedge sys_clk);
            check(i == 1, ctlRst);
            check(i == 1, alOe);
            ctl(32'h0000_0703);
            repeat (40) @(posedge sys_clk);
            check(1'b0, boost);
            ctl(32'h0000_0700);
        end
        {extRst, card_present_input, alarm, fault} <= 4'b1100;
        repeat (5) @(posedge sys_clk);
        check(1'b1, ctlRst);
        extRst <= 1'b0;
        mask = 4'($urandom);
        bus(1'b1, cssq_pkg::MASK_OFFSET, {28'h000_0000, mask});
        bus(1'b0, cssq_pkg::EVENT_OFFSET);
        check(1'b1, offSt);
        ctl(32'h0000_0703);
        waitFor(boost, 1'b1);
        check(1'b0, vcc);
        waitFor(vcc, 1'b1);
        check(1'b0, low_impedance_supply);
        waitFor(cClk, 1'b1);
        repeat (2) @(posedge sys_clk);
        check(1'b1, cRst);
        check(expIrq(4'h1, mask), irq);
        ctl(32'h0000_0701);
        repeat (3) @(posedge sys_clk);
        check(2'b00, {cClk, cRst});
        dBit = 1'($urandom);
        ctl({29'h0000_00E0, dBit, 2'b11});
        repeat (3) @(posedge sys_clk);
        check({dBit, 3'b111}, {dOut, dOe, cClk, cRst});
        // Card pulled out mid-session
        card_present_input <= 1'b0;
        repeat (5) @(posedge sys_clk);
        check(1'b0, offSt);
        waitFor(vcc, 1'b0);
        check(2'b00, {cClk, dOe});
        waitFor(boost, 1'b0);
        check(1'b1, low_impedance_supply);
        bus(1'b0, cssq_pkg::EVENT_OFFSET);
        check(32'h0000_000F, rd);
        repeat (2) @(posedge sys_clk);
        check(1'b0, irq);
        ctl(32'h0000_0700);
        card_present_input <= 1'b1;
        // Supply loss, alarm and fault during a session
        for (i = 0; i < 3; i++)
        begin
            waitFor(offSt, 1'b1);
            ctl(32'h0000_0703);
            waitFor(cClk, 1'b1);
            {pg, alarm, fault} <= {i != 0, i == 1, i == 2};
            waitFor(vcc, 1'b0);
            check(2'b00, {vcc, offSt});
            {pg, alarm, fault} <= 3'b100;
            ctl(32'h0000_0700);
            waitFor(boost, 1'b0);
        end
        results();
    end
endmodule : tb
